// [tb/manchester_program_port_tb.sv]
// testbench of the manchester programming port
`timescale 1ns/100ps
`default_nettype none
`include "mpp_defs.svh"
module manchester_program_port_tb;
    localparam int T  = 40;
    localparam int EE = 100;
    localparam int TE = 50;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        sup = 1'b0;
    logic        pen = 1'b0;
    logic        lock = 1'b0;
    logic [25:0] rdata = 26'h2ABCDEF;
    logic [1:0]  ecc = 2'h2;
    logic        pin_o, pin_oe, ana, unl, vol_we, ee_we, drv, lvl, oe_q;
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic [33:0] w;
    wire         line;
    int          fail_count = 0, n_checks = 0, n_vol = 0, n_ee = 0;
    int          n_oe = 0, cyc = 0, ee_cyc = 0, oe_cyc = 0, bad;

    // pull-down on the pin when nobody drives
    assign line = pin_oe ? pin_o : (drv ? lvl : 1'b0);
    always #2 clk = ~clk;

    manchester_program_port #(
        .ACC_CYCLES(20000), .EE_CYCLES(EE), .TE_CYCLES(TE)
    ) manchester_program_port_inst (
        .clk_i(clk), .arst_n_i(arst_n), .supply_prog_level_i(sup),
        .program_enable_pin_i(pen), .sensor_output_pin_i(line),
        .permanent_lock_bit_i(lock), .mem_rdata_i(rdata),
        .mem_ecc_i(ecc), .sensor_output_pin_o(pin_o),
        .sensor_output_pin_oe_o(pin_oe), .analog_enable_o(ana),
        .session_unlocked_o(unl), .mem_addr_o(addr),
        .mem_wdata_o(wdata), .mem_vol_we_o(vol_we), .mem_ee_we_o(ee_we)
    );

    prog_ctl_model #(.T(T)) prog_ctl_model_inst (
        .clk_i(clk), .wire_i(line), .drv_o(drv), .lvl_o(lvl)
    );

    always @(posedge clk)
    begin
        cyc++;
        if (vol_we === 1'b1)
            n_vol++;
        if (ee_we === 1'b1)
        begin
            n_ee++;
            ee_cyc = cyc;
        end
        if (pin_oe === 1'b1 && oe_q !== 1'b1)
        begin
            n_oe++;
            oe_cyc = cyc;
        end
        oe_q <= pin_oe;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (!ok)
        begin
            fail_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wait_oe(input int lim);
        int n;
        n = 0;
        while (pin_oe !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk(pin_oe === 1'b1, "no drive from device");
    endtask : wait_oe

    function automatic logic [5:0] ecc6(input logic [25:0] p);
        logic [5:0] e;
        e = 6'h00;
        for (int j = 0; j < 26; j++)
        begin
            for (int i = 0; i < 5; i++)
                if (((j + 1) >> i) & 1)
                    e[i] ^= p[j];
            e[5] ^= p[j];
        end
        return e;
    endfunction : ecc6

    // sync, direction, address, data, crc; read frames left aligned
    function automatic logic [43:0] frame(input logic rd,
                                          input logic [5:0] a,
                                          input logic [31:0] d);
        logic [43:0] f;
        logic [2:0]  c;
        f = rd ? {3'b001, a, 35'h0} : {3'b000, a, d, 3'h0};
        c = `CRC_SEED;
        for (int i = 43; i > (rd ? 34 : 2); i--)
            c = {c[1:0], 1'b0} ^ ((c[2] ^ f[i]) ? `CRC_POLY : 3'h0);
        if (rd)
            f[34:32] = c;
        else
            f[2:0] = c;
        return f;
    endfunction : frame

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(4);
        arst_n <= 1'b1;
        tick(1);
        chk(ana === 1'b1 && pin_oe === 1'b0 && unl === 1'b0, "reset");
        sup <= 1'b1;
        tick(6);
        chk(ana === 1'b0 && pin_oe === 1'b0, "no serial mode");
        prog_ctl_model_inst.send(frame(1'b1, 6'h07, 32'h0), 12);
        tick(4 * T);
        chk(n_oe === 0, "locked read answered");
        prog_ctl_model_inst.send(frame(1'b0, `ACC_ADDR, `ACC_CODE), 44);
        chk(unl === 1'b1 && n_vol === 0, "access code");
        prog_ctl_model_inst.send(frame(1'b0, 6'h21, 32'hFC001234), 44);
        chk(n_vol === 1 && addr === 6'h21, "volatile write");
        chk(wdata === {ecc6(26'h1234), 26'h1234}, "write word");
        chk(n_oe === 0, "write answered");
        prog_ctl_model_inst.send(frame(1'b0, 6'h22, 32'h5) ^ 44'h1, 44);
        chk(n_vol === 1 && n_oe === 0, "bad crc taken");
        prog_ctl_model_inst.send(frame(1'b0, 6'h05, 32'h03FFFFFF), 44);
        chk(n_ee === 1 && wdata === {ecc6(26'h3FFFFFF), 26'h3FFFFFF},
            "eeprom write");
        wait_oe(EE + 2 * T);
        tick(T / 2);
        chk(oe_cyc - ee_cyc == EE, "eeprom delay wrong");
        chk(line === 1'b1, "ack high");
        tick(T);
        chk(line === 1'b0, "ack low");
        tick(T);
        chk(pin_oe === 1'b0, "ack not released");
        prog_ctl_model_inst.send(frame(1'b1, 6'h07, 32'h0), 12);
        wait_oe(4 * T);
        prog_ctl_model_inst.recv(w, bad);
        chk(w === {2'b00, 4'h0, ecc, rdata} && bad == 0, "read reply");
        chk(addr === 6'h07 && n_oe === 2, "read addr");
        tick(2 * T);
        sup <= 1'b0;
        tick(5);
        chk(pin_oe === 1'b0 && ana === 1'b0, "exit");
        tick(TE - 9);
        chk(ana === 1'b0, "analog early");
        tick(14);
        chk(ana === 1'b1, "analog late");
        arst_n <= 1'b0;
        lock <= 1'b1;
        tick(2);
        arst_n <= 1'b1;
        pen <= 1'b1;
        tick(6);
        chk(ana === 1'b0 && unl === 1'b0, "pin enable");
        prog_ctl_model_inst.send(frame(1'b0, `ACC_ADDR, `ACC_CODE), 44);
        chk(unl === 1'b0, "lock bypassed");
        finish_test();
    end

    initial
    begin
        tick(40000);
        fail_count++;
        finish_test();
    end
endmodule : manchester_program_port_tb
`default_nettype wire

// [tb/prog_ctl_model.sv]
// programming controller model driving the sensor output pin
`timescale 1ns/100ps
`default_nettype none
module prog_ctl_model #(
    parameter int T = 40
) (
    input  wire logic clk_i,
    input  wire logic wire_i,
    output logic      drv_o,
    output logic      lvl_o
);
    initial
    begin
        drv_o = 1'b0;
        lvl_o = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask : hold

    ////////////////////////////////////////////////////////////////////////
    // low lead-in, manchester bits, still tail, then release
    task automatic send(input logic [43:0] f, input int len);
        drv_o <= 1'b1;
        lvl_o <= 1'b0;
        hold(T);
        for (int i = 43; i > 43 - len; i--)
        begin
            lvl_o <= f[i];
            hold(T / 2);
            lvl_o <= ~f[i];
            hold(T / 2);
        end
        hold(2 * T);
        drv_o <= 1'b0;
    endtask : send

    ////////////////////////////////////////////////////////////////////////
    // resyncs on every mid-bit edge, counts missing half inversions
    task automatic recv(output logic [33:0] w, output int bad);
        logic a;
        int   n;
        bad = 0;
        hold(T / 4);
        for (int i = 33; i >= 0; i--)
        begin
            a = wire_i;
            w[i] = a;
            n = 0;
            while (wire_i === a && n < T)
            begin
                @(posedge clk_i);
                n++;
            end
            hold(T / 4);
            if (wire_i !== ~a)
                bad++;
            if (i > 0)
                hold(T / 2);
        end
    endtask : recv
endmodule : prog_ctl_model
`default_nettype wire

// [verilog/manchester_program_port.sv]
// serial programming port on the sensor output pin
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mpp_defs.svh"
module manchester_program_port #(
    parameter int unsigned ACC_CYCLES = `ACC_CYC,
    parameter int unsigned EE_CYCLES  = `EE_CYC,
    parameter int unsigned TE_CYCLES  = `TE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        supply_prog_level_i,
    input  wire logic        program_enable_pin_i,
    input  wire logic        sensor_output_pin_i,
    input  wire logic        permanent_lock_bit_i,
    input  wire logic [25:0] mem_rdata_i,
    input  wire logic [1:0]  mem_ecc_i,
    output logic             sensor_output_pin_o,
    output logic             sensor_output_pin_oe_o,
    output logic             analog_enable_o,
    output logic             session_unlocked_o,
    output logic [5:0]       mem_addr_o,
    output logic [31:0]      mem_wdata_o,
    output logic             mem_vol_we_o,
    output logic             mem_ee_we_o
);

    localparam logic [23:0] ACC_LAST = 24'(ACC_CYCLES - 1);
    localparam logic [23:0] EE_LAST = 24'(EE_CYCLES - 1);
    localparam logic [23:0] TE_LAST = 24'(TE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // frame crc and memory ecc helpers

    function automatic logic [2:0] crc3(input logic [43:0] v,
                                        input logic [5:0]  len);
        logic [2:0] c;
        logic       fb;
        c = `CRC_SEED;
        fb = 1'b0;
        for (int i = 43; i >= 3; i--)
        begin
            if (6'(i) < len)
            begin
                fb = c[2] ^ v[i];
                c = {c[1:0], 1'b0} ^ ({3{fb}} & `CRC_POLY);
            end
        end
        return c;
    endfunction : crc3

    function automatic logic [5:0] ecc6(input logic [25:0] d);
        logic [5:0] e;
        logic [4:0] k;
        e = 6'h00;
        k = 5'h00;
        for (int j = 0; j < 26; j++)
        begin
            k = 5'(j + 1);
            for (int i = 0; i < 5; i++)
                if (k[i])
                    e[i] = e[i] ^ d[j];
            e[5] = e[5] ^ d[j];
        end
        return e;
    endfunction : ecc6

    ////////////////////////////////////////////////////////////////////////
    // state and receiver

    mpp_pkg::port_regs_type q;
    mpp_pkg::port_regs_type n;
    logic                   pe;
    logic                   serial;
    logic                   is_wr;
    logic                   is_rd;
    logic                   crc_ok;
    logic                   access;
    logic [5:0]             wr_addr;
    logic [31:0]            wr_data;
    logic [23:0]            per_last;
    logic [23:0]            half_last;
    logic [23:0]            gap_last;

    rx_link_if lnk ();

    manchester_rx manchester_rx_inst (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .lnk      (lnk.rx)
    );

    assign pe = q.sup_s2 | q.pen_s2;
    assign serial = q.st != mpp_pkg::ST_ANALOG && q.st != mpp_pkg::ST_EXIT;
    assign lnk.line = q.pin_s2;
    // receiver deaf while the device itself drives the pin
    assign lnk.listen = q.st == mpp_pkg::ST_LISTEN;
    assign per_last = {4'h0, lnk.per} - 24'h000001;
    assign half_last = {5'h00, lnk.per[19:1]} - 24'h000001;
    assign gap_last = {3'h0, lnk.per, 1'b0} - 24'h000001;

    // frame layout in arrival order, newest bit at sh[0]
    assign is_wr = q.nbits == `WR_BITS && q.sh[43:41] == 3'b000;
    assign is_rd = q.nbits == `RD_BITS && q.sh[11:9] == 3'b001;
    assign crc_ok = crc3(q.sh, q.nbits) == q.sh[2:0];
    assign wr_addr = q.sh[40:35];
    assign wr_data = q.sh[34:3];
    assign access = q.unlocked && !q.lock_perm;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        n = q;
        n.mem_we = 1'b0;
        n.mem_ee_we = 1'b0;
        n.pin_s1 = sensor_output_pin_i;
        n.pin_s2 = q.pin_s1;
        n.sup_s1 = supply_prog_level_i;
        n.sup_s2 = q.sup_s1;
        n.pen_s1 = program_enable_pin_i;
        n.pen_s2 = q.pen_s1;
        n.tmr = q.tmr + 24'h000001;
        // access code window runs once after reset
        if (q.acc_open)
        begin
            if (q.acc_tmr == ACC_LAST)
                n.acc_open = 1'b0;
            else
                n.acc_tmr = q.acc_tmr + 24'h000001;
        end
        // lock level caught once after reset release
        if (!q.lock_seen)
        begin
            n.lock_seen = 1'b1;
            n.lock_perm = permanent_lock_bit_i;
        end
        if (lnk.stb)
        begin
            n.sh = {q.sh[42:0], lnk.val};
            if (q.nbits != `BITS_MAX)
                n.nbits = q.nbits + 6'h01;
        end
        unique case (q.st)
            mpp_pkg::ST_ANALOG:
                if (pe)
                begin
                    n.ana_en = 1'b0;
                    n.st = mpp_pkg::ST_LISTEN;
                end
            mpp_pkg::ST_LISTEN:
                if (lnk.fend)
                begin
                    n.sh = 44'h00000000000;
                    n.nbits = 6'h00;
                    n.tmr = 24'h000000;
                    // anything else is dropped silently
                    if (crc_ok && is_wr)
                    begin
                        if (wr_addr == `ACC_ADDR)
                        begin
                            if (wr_data == `ACC_CODE && q.acc_open
                                && !q.lock_perm)
                                n.unlocked = 1'b1;
                        end
                        else if (access)
                        begin
                            n.mem_addr = wr_addr;
                            n.mem_wdata = {ecc6(wr_data[25:0]),
                                           wr_data[25:0]};
                            if (wr_addr <= `EE_LAST)
                            begin
                                n.mem_ee_we = 1'b1;
                                n.st = mpp_pkg::ST_EE_WAIT;
                            end
                            else
                                n.mem_we = 1'b1;
                        end
                    end
                    else if (crc_ok && is_rd && access)
                    begin
                        n.mem_addr = q.sh[8:3];
                        n.st = mpp_pkg::ST_RD_GAP;
                    end
                end
            mpp_pkg::ST_EE_WAIT:
                if (q.tmr == EE_LAST)
                begin
                    n.tmr = 24'h000000;
                    n.pin_oe = 1'b1;
                    n.pin_o = 1'b1;
                    n.st = mpp_pkg::ST_EE_ACK;
                end
            mpp_pkg::ST_EE_ACK:
                if (q.tmr == per_last)
                begin
                    n.tmr = 24'h000000;
                    if (q.pin_o)
                        n.pin_o = 1'b0;
                    else
                    begin
                        n.pin_oe = 1'b0;
                        n.st = mpp_pkg::ST_LISTEN;
                    end
                end
            mpp_pkg::ST_RD_GAP:
                // two bit times for the controller to let go
                if (q.tmr == gap_last)
                begin
                    n.tmr = 24'h000000;
                    n.txsh = {2'b00, 4'h0, mem_ecc_i, mem_rdata_i};
                    n.txcnt = `TX_BITS;
                    n.ph = 1'b0;
                    n.pin_oe = 1'b1;
                    n.pin_o = 1'b0;
                    n.st = mpp_pkg::ST_RD_TX;
                end
            mpp_pkg::ST_RD_TX:
                if (q.tmr == half_last)
                begin
                    n.tmr = 24'h000000;
                    if (!q.ph)
                    begin
                        n.ph = 1'b1;
                        n.pin_o = ~q.pin_o;
                    end
                    else
                    begin
                        n.ph = 1'b0;
                        n.txsh = {q.txsh[32:0], 1'b0};
                        n.txcnt = q.txcnt - 6'h01;
                        if (q.txcnt == 6'h01)
                        begin
                            n.pin_oe = 1'b0;
                            n.pin_o = 1'b0;
                            n.st = mpp_pkg::ST_LISTEN;
                        end
                        else
                            n.pin_o = q.txsh[32];
                    end
                end
            mpp_pkg::ST_EXIT:
                if (pe)
                begin
                    n.tmr = 24'h000000;
                    n.st = mpp_pkg::ST_LISTEN;
                end
                else if (q.tmr == TE_LAST)
                begin
                    n.ana_en = 1'b1;
                    n.st = mpp_pkg::ST_ANALOG;
                end
            default:
                n.st = mpp_pkg::ST_EXIT;
        endcase
        if (!pe && serial)
        begin
            n.st = mpp_pkg::ST_EXIT;
            n.tmr = 24'h000000;
            n.pin_oe = 1'b0;
            n.pin_o = 1'b0;
            n.mem_we = 1'b0;
            n.mem_ee_we = 1'b0;
            n.sh = 44'h00000000000;
            n.nbits = 6'h00;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            q <= '{st: mpp_pkg::ST_ANALOG, ana_en: `ANA_RST,
                   acc_open: `ACC_OPEN_RST, default: '0};
        else
            q <= n;
    end

    assign sensor_output_pin_o = q.pin_o;
    assign sensor_output_pin_oe_o = q.pin_oe;
    assign analog_enable_o = q.ana_en;
    assign session_unlocked_o = q.unlocked;
    assign mem_addr_o = q.mem_addr;
    assign mem_wdata_o = q.mem_wdata;
    assign mem_vol_we_o = q.mem_we;
    assign mem_ee_we_o = q.mem_ee_we;

    ////////////////////////////////////////////////////////////////////////
    // checks

    no_spont_tx_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(q.pin_oe) |-> ($past(q.st) == mpp_pkg::ST_RD_GAP
                             || $past(q.st) == mpp_pkg::ST_EE_WAIT))
        else $error("pin driven without a command");

    write_silent_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        q.mem_we |-> !q.pin_oe ##1 q.st != mpp_pkg::ST_RD_GAP)
        else $error("reply after volatile write");

    analog_off_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        pe |=> !q.ana_en)
        else $error("analog driver on in program mode");

    stop_serial_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !pe |=> !q.pin_oe && !q.mem_we && !q.mem_ee_we)
        else $error("serial activity without enable");

    resume_delay_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(q.ana_en) |-> $past(q.st) == mpp_pkg::ST_EXIT
                            && $past(q.tmr) == TE_LAST)
        else $error("analog resumed at wrong time");

    ee_done_edge_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (q.st == mpp_pkg::ST_EE_ACK && $past(q.st) == mpp_pkg::ST_EE_WAIT)
        |-> q.pin_oe && q.pin_o && $past(q.tmr) == EE_LAST)
        else $error("eeprom completion not high after delay");

    ee_quiet_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        q.st == mpp_pkg::ST_EE_WAIT |-> !q.pin_oe)
        else $error("pin driven during eeprom write");

    mid_bit_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (q.st == mpp_pkg::ST_RD_TX && $rose(q.ph))
        |-> q.pin_o != $past(q.pin_o))
        else $error("no mid-bit transition");

    perm_lock_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        q.lock_perm |-> !q.mem_we && !q.mem_ee_we
                        && q.st != mpp_pkg::ST_RD_GAP)
        else $error("access while permanently locked");

    ecc_store_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        q.mem_ee_we |-> q.mem_wdata[31:26] == ecc6(q.mem_wdata[25:0]))
        else $error("stored ecc does not match payload");

endmodule : manchester_program_port
`default_nettype wire

// [verilog/manchester_rx.sv]
// manchester bit receiver with period recovery
`timescale 1ns/100ps
`default_nettype none
`include "mpp_defs.svh"
module manchester_rx (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    rx_link_if.rx     lnk
);

    mpp_pkg::rx_regs_type q;
    mpp_pkg::rx_regs_type n;
    logic                 rise;
    logic                 fall;
    logic [19:0]          thr;
    logic [19:0]          lim;

    assign rise = lnk.line & ~q.prev;
    assign fall = ~lnk.line & q.prev;
    // edges before 3/4 bit are boundary edges
    assign thr = {1'b0, q.per[19:1]} + {2'b00, q.per[19:2]};
    assign lim = q.per + {1'b0, q.per[19:1]};
    assign lnk.stb = q.stb;
    assign lnk.val = q.val;
    assign lnk.fend = q.fend;
    assign lnk.per = q.per;

    always_comb
    begin
        n = q;
        n.stb = 1'b0;
        n.fend = 1'b0;
        n.prev = lnk.line;
        // 20 bit count covers the slowest bit time
        if (q.cnt != `CNT_MAX)
            n.cnt = q.cnt + 20'h00001;
        if (!lnk.listen)
        begin
            n.st = mpp_pkg::RX_IDLE;
            n.cnt = 20'h00000;
        end
        else
        begin
            unique case (q.st)
                mpp_pkg::RX_IDLE:
                    if (rise)
                    begin
                        n.stb = 1'b1;
                        n.val = 1'b0;
                        n.cnt = 20'h00000;
                        n.st = mpp_pkg::RX_MEAS;
                    end
                mpp_pkg::RX_MEAS:
                    if (rise)
                    begin
                        n.per = q.cnt + 20'h00001;
                        n.stb = 1'b1;
                        n.val = 1'b0;
                        n.cnt = 20'h00000;
                        n.st = mpp_pkg::RX_RUN;
                    end
                    else if (q.cnt == `CNT_MAX)
                    begin
                        n.fend = 1'b1;
                        n.st = mpp_pkg::RX_IDLE;
                    end
                mpp_pkg::RX_RUN:
                    if ((rise | fall) && q.cnt >= thr)
                    begin
                        n.stb = 1'b1;
                        n.val = fall;
                        n.cnt = 20'h00000;
                    end
                    else if (q.cnt > lim)
                    begin
                        n.fend = 1'b1;
                        n.st = mpp_pkg::RX_IDLE;
                    end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            q <= '{st: mpp_pkg::RX_IDLE, default: '0};
        else
            q <= n;
    end

    bit_window_a: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (q.st == mpp_pkg::RX_RUN && q.stb && $past(q.st) == mpp_pkg::RX_RUN)
        |-> $past(q.cnt) >= $past(thr))
        else $error("bit taken before three quarter bit");

endmodule : manchester_rx
`default_nettype wire

// [verilog/mpp_defs.svh]
// constants of the manchester programming port
`ifndef MPP_DEFS_SVH
`define MPP_DEFS_SVH

`define CLK_MHZ      250
`define UNLOCK_TIMEOUT_MS     10
`define T_W_MS       20
`define T_E_US       125
`define ACC_CYC      (`UNLOCK_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define EE_CYC       (`T_W_MS * 1000 * `CLK_MHZ)
`define TE_CYC       (`T_E_US * `CLK_MHZ)

`define RD_BITS      6'h0C
`define WR_BITS      6'h2C
`define TX_BITS      6'h22
`define BITS_MAX     6'h3F
`define ACC_ADDR     6'h36
`define ACC_CODE     32'hC4136737
`define EE_LAST      6'h1F
`define CRC_POLY     3'h3
`define CRC_SEED     3'h0
`define CNT_MAX      20'hFFFFF
`define ANA_RST      1'b1
`define ACC_OPEN_RST 1'b1

`endif

// [verilog/mpp_pkg.sv]
// types of the manchester programming port
`default_nettype none
package mpp_pkg;

    typedef enum logic [6:0] {
        ST_ANALOG = 7'h01,
        ST_LISTEN = 7'h02,
        ST_EE_WAIT = 7'h04,
        ST_EE_ACK = 7'h08,
        ST_RD_GAP = 7'h10,
        ST_RD_TX = 7'h20,
        ST_EXIT = 7'h40
    } port_state_type;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h1,
        RX_MEAS = 3'h2,
        RX_RUN = 3'h4
    } rx_state_type;

    typedef struct packed {
        rx_state_type st;
        logic         prev;
        logic [19:0]  cnt;
        logic [19:0]  per;
        logic         stb;
        logic         val;
        logic         fend;
    } rx_regs_type;

    typedef struct packed {
        port_state_type st;
        logic           pin_s1;
        logic           pin_s2;
        logic           sup_s1;
        logic           sup_s2;
        logic           pen_s1;
        logic           pen_s2;
        logic [43:0]    sh;
        logic [5:0]     nbits;
        logic [23:0]    tmr;
        logic [23:0]    acc_tmr;
        logic           acc_open;
        logic           unlocked;
        logic           lock_seen;
        logic           lock_perm;
        logic [33:0]    txsh;
        logic [5:0]     txcnt;
        logic           ph;
        logic           pin_o;
        logic           pin_oe;
        logic           ana_en;
        logic [5:0]     mem_addr;
        logic [31:0]    mem_wdata;
        logic           mem_we;
        logic           mem_ee_we;
    } port_regs_type;

endpackage : mpp_pkg
`default_nettype wire

// [verilog/rx_link_if.sv]
// link between frame logic and manchester receiver
`timescale 1ns/100ps
`default_nettype none
interface rx_link_if;
    logic        line;
    logic        listen;
    logic        stb;
    logic        val;
    logic        fend;
    logic [19:0] per;

    modport ctl (output line, output listen,
                 input stb, input val, input fend, input per);
    modport rx  (input line, input listen,
                 output stb, output val, output fend, output per);
endinterface : rx_link_if
`default_nettype wire
